// *** hw/trgx_pkg.sv ***
// Purpose: Shared constants and types for the trigger export router.
// Assumes: One 20 MHz clock, no register bus, plain control ports.
// Notes: Terminal codes fill the routing table of the router.
package trgx_pkg;
   // Exportable signal indices.
   localparam int SIG_START = 0;
   localparam int SIG_REF = 1;
   localparam int SIG_ADVANCE = 2;
   localparam int SIG_RDY_START = 3;
   localparam int SIG_RDY_ADVANCE = 4;
   localparam int SIG_RDY_REF = 5;
   localparam int SIG_RECORD_COMPLETE = 6;
   localparam int SIG_DONE = 7;
   localparam int NUM_SIGNALS = 8;
   // Terminal codes: 0 is no export, 1..2 function lines, 3..10 backplane
   // trigger lines, 11 the star trigger line.
   localparam logic [3:0] TERM_NONE = 4'h0;
   localparam logic [3:0] TERM_PFL_FIRST = 4'h1;
   localparam logic [3:0] TERM_BPT_FIRST = 4'h3;
   localparam logic [3:0] TERM_STAR = 4'hB;
   localparam int NUM_PFL = 2;
   localparam int NUM_BPT = 8;
   localparam int NUM_TERMS = 11;
   // Reference clock lock source.
   typedef enum logic [1:0] {
      TRGX_REF_INTERNAL = 2'b00,
      TRGX_REF_EXT_IN = 2'b01,
      TRGX_REF_BACKPLANE = 2'b10
   } trgx_ref_src_t;
   // Backplane clock driver source.
   typedef enum logic [1:0] {
      TRGX_BPC_NONE = 2'b00,
      TRGX_BPC_INTERNAL = 2'b01,
      TRGX_BPC_EXT_IN = 2'b10
   } trgx_bpc_src_t;
   localparam logic [1:0] REF_SRC_RESET = 2'h0;
   localparam logic [1:0] BPC_SRC_RESET = 2'h0;
   // Reference rate in Hz; the only supported value.
   localparam logic [31:0] REF_RATE_HZ = 32'h0098_9680;
   localparam logic [3:0] REQUIRED_SLOT = 4'h2;
   // Full clock configuration, shadowed and committed as one word.
   typedef struct packed {
      trgx_ref_src_t ref_src;
      trgx_bpc_src_t bpc_src;
   } trgx_clk_cfg_t;
   // Session control strobes.
   typedef struct packed {
      logic commit;
      logic close;
      logic dev_reset;
   } trgx_ctl_t;
   // Driven terminal group.
   typedef struct packed {
      logic [NUM_PFL-1:0] pfl;
      logic [NUM_BPT-1:0] bpt;
      logic star;
   } trgx_term_t;
endpackage : trgx_pkg

// *** hw/trgx_route.sv ***
// Purpose: Active routing table and terminal drive for the export router.
// Assumes: Selections arrive already validated, with a commit strobe.
// Notes: Backplane trigger lines stay released after a close until a commit.
`timescale 1ns/10ps
module trgx_route #(
   parameter int NSIG = trgx_pkg::NUM_SIGNALS
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [NSIG*4-1:0] shadow_i,
   input wire trgx_pkg::trgx_ctl_t ctl_i,
   input wire logic [NSIG-1:0] sig_i,
   output trgx_pkg::trgx_term_t term_o,
   output trgx_pkg::trgx_term_t oe_o
);
   // The terminal decode below serves exactly the package signal count.
   if (NSIG != trgx_pkg::NUM_SIGNALS) begin : g_bad_nsig
      $error("NSIG must equal the package signal count.");
   end
   typedef struct packed {
      logic [NSIG*4-1:0] active;
      logic bpt_block;
      trgx_pkg::trgx_term_t term;
      trgx_pkg::trgx_term_t oe;
   } trgx_route_st_t;
   trgx_route_st_t st;
   trgx_route_st_t next_st;
   logic [trgx_pkg::NUM_TERMS:0] drv;
   logic [trgx_pkg::NUM_TERMS:0] val;

   // Decode the active table into per terminal drive and value.
   always_comb begin
      drv = '0;
      val = '0;
      for (int s = 0; s < NSIG; s++) begin
         if (st.active[s*4 +: 4] != trgx_pkg::TERM_NONE) begin
            drv[st.active[s*4 +: 4]] = 1'b1;
            val[st.active[s*4 +: 4]] = val[st.active[s*4 +: 4]] | sig_i[s];
         end
      end
   end

   // Update the table on commit and clear it on device reset.
   always_comb begin
      next_st = st;
      if (ctl_i.dev_reset) begin
         next_st.active = '0;
         next_st.bpt_block = 1'b0;
      end else if (ctl_i.commit) begin
         next_st.active = shadow_i;
         next_st.bpt_block = 1'b0;
      end else if (ctl_i.close) begin
         next_st.bpt_block = 1'b1;
      end
      next_st.oe.pfl = drv[2:1];
      next_st.oe.bpt = st.bpt_block ? '0 : drv[10:3];
      next_st.oe.star = st.bpt_block ? 1'b0 : drv[11];
      next_st.term.pfl = val[2:1];
      next_st.term.bpt = val[10:3];
      next_st.term.star = val[11];
      if (ctl_i.dev_reset) begin
         next_st.oe = '0;
      end
   end

   // State register.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign term_o = st.term;
   assign oe_o = st.oe;
endmodule : trgx_route

// *** hw/trgx_clksel.sv ***
// Purpose: Reference clock source and backplane clock driver selection.
// Assumes: Slot number is a static input from the chassis.
// Notes: Settings are validated upstream; this block only commits them.
`timescale 1ns/10ps
module trgx_clksel (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire trgx_pkg::trgx_clk_cfg_t shadow_i,
   input wire logic commit_i,
   output trgx_pkg::trgx_clk_cfg_t active_o
);
   typedef struct packed {
      trgx_pkg::trgx_clk_cfg_t active;
   } trgx_clk_st_t;
   trgx_clk_st_t st;
   trgx_clk_st_t next_st;

   // Commit the shadow configuration in one step.
   always_comb begin
      next_st = st;
      if (commit_i) begin
         next_st.active = shadow_i;
      end
   end

   // State register.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '{active: '{ref_src: trgx_pkg::TRGX_REF_INTERNAL,
                           bpc_src: trgx_pkg::TRGX_BPC_NONE}};
      end else begin
         st <= next_st;
      end
   end
   assign active_o = st.active;
endmodule : trgx_clksel

// *** hw/trgx_top.sv ***
// Purpose: Trigger and event export router with reference clock selection.
// Assumes: Control strobes are one-cycle pulses synchronous to CLK_I.
// Notes: Terminal pins are split into value and output enable.
`timescale 1ns/10ps
module trgx_top (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [trgx_pkg::NUM_SIGNALS-1:0] EVENT_I,
   input wire logic SEL_WR_I,
   input wire logic [2:0] SEL_SIG_I,
   input wire logic [3:0] SEL_TERM_I,
   input wire logic REF_WR_I,
   input wire logic [1:0] REF_SRC_I,
   input wire logic [31:0] REF_RATE_I,
   input wire logic BPC_WR_I,
   input wire logic [1:0] BPC_SRC_I,
   input wire logic [3:0] SLOT_I,
   input wire trgx_pkg::trgx_ctl_t CTL_I,
   output trgx_pkg::trgx_term_t TERM_O,
   output trgx_pkg::trgx_term_t TERM_OE_O,
   output trgx_pkg::trgx_clk_cfg_t CLK_CFG_O,
   output logic REFUSED_O
);
   typedef struct packed {
      logic [trgx_pkg::NUM_SIGNALS*4-1:0] shadow;
      trgx_pkg::trgx_clk_cfg_t clk_shadow;
      logic refused;
   } trgx_top_st_t;
   trgx_top_st_t st;
   trgx_top_st_t next_st;
   logic ref_ok;
   logic bpc_ok;
   logic term_ok;

   // Validate requested settings.
   always_comb begin
      term_ok = SEL_TERM_I <= trgx_pkg::TERM_STAR;
      ref_ok = (REF_SRC_I == trgx_pkg::TRGX_REF_INTERNAL) ||
               (REF_SRC_I == trgx_pkg::TRGX_REF_EXT_IN) ||
               (REF_SRC_I == trgx_pkg::TRGX_REF_BACKPLANE);
      ref_ok = ref_ok && (REF_RATE_I == trgx_pkg::REF_RATE_HZ);
      bpc_ok = (SLOT_I == trgx_pkg::REQUIRED_SLOT) &&
               (BPC_SRC_I != 2'h3);
   end

   // Shadow storage written by selection strobes; refusals pulse.
   always_comb begin
      next_st = st;
      next_st.refused = 1'b0;
      if (CTL_I.dev_reset) begin
         next_st.shadow = '0;
      end else if (SEL_WR_I && term_ok) begin
         next_st.shadow[SEL_SIG_I*4 +: 4] = SEL_TERM_I;
      end
      // A bad terminal code is refused even when a device reset coincides.
      if (SEL_WR_I && !term_ok) begin
         next_st.refused = 1'b1;
      end
      if (REF_WR_I) begin
         if (ref_ok) begin
            next_st.clk_shadow.ref_src = trgx_pkg::trgx_ref_src_t'(REF_SRC_I);
         end else begin
            next_st.refused = 1'b1;
         end
      end
      if (BPC_WR_I) begin
         if (bpc_ok) begin
            next_st.clk_shadow.bpc_src = trgx_pkg::trgx_bpc_src_t'(BPC_SRC_I);
         end else begin
            next_st.refused = 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st <= '{shadow: '0,
                 clk_shadow: '{ref_src: trgx_pkg::TRGX_REF_INTERNAL,
                               bpc_src: trgx_pkg::TRGX_BPC_NONE},
                 refused: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Routing table and terminal drive.
   trgx_route u_route (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .shadow_i(st.shadow),
      .ctl_i(CTL_I),
      .sig_i(EVENT_I),
      .term_o(TERM_O),
      .oe_o(TERM_OE_O)
   );

   // Clock source selection.
   trgx_clksel u_clk (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .shadow_i(st.clk_shadow),
      .commit_i(CTL_I.commit),
      .active_o(CLK_CFG_O)
   );
   assign REFUSED_O = st.refused;
endmodule : trgx_top

// *** verif/trgx_peer.sv ***
// Purpose: Chassis side of the exported terminal lines.
// Assumes: Every line carries a pull-up on the far side.
// Notes: A released line reads high, never its last value.
`timescale 1ns/10ps
module trgx_peer (
   input wire trgx_pkg::trgx_term_t term_i,
   input wire trgx_pkg::trgx_term_t oe_i,
   output trgx_pkg::trgx_term_t lvl_o
);
   // Resolves each line from the router drive and the pull-up.
   assign lvl_o = (term_i & oe_i) | ~oe_i;
endmodule : trgx_peer

// *** verif/trgx_top_sva.sv ***
// Purpose: Port assertions for the export router.
// Assumes: Control strobes are single-cycle pulses.
// Notes: Bound onto every router top instance.
`timescale 1ns/10ps
module trgx_top_sva (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic SEL_WR_I,
   input wire logic [3:0] SEL_TERM_I,
   input wire logic REF_WR_I,
   input wire logic [31:0] REF_RATE_I,
   input wire logic BPC_WR_I,
   input wire logic [3:0] SLOT_I,
   input wire trgx_pkg::trgx_ctl_t CTL_I,
   input wire trgx_pkg::trgx_term_t TERM_OE_O,
   input wire trgx_pkg::trgx_clk_cfg_t CLK_CFG_O,
   input wire logic REFUSED_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Two cycles in a row with no control strobe.
   sequence quiet2;
      (CTL_I == 3'h0) [*2];
   endsequence
   // A close that no commit or reset in the same cycle can overtake.
   sequence clean_close;
      CTL_I.close && !CTL_I.commit && !CTL_I.dev_reset;
   endsequence
   oe_hold_a: assert property (quiet2 |=> $stable(TERM_OE_O))
      else $error("Terminal enables moved without a strobe.");
   cfg_hold_a: assert property (!CTL_I.commit && !CTL_I.dev_reset
      |=> $stable(CLK_CFG_O)) else $error("Clock setup moved alone.");
   close_bpt_a: assert property (clean_close |-> ##2
      (TERM_OE_O.bpt == 8'h00 && !TERM_OE_O.star))
      else $error("Backplane line still driven after close.");
   // A device reset right after the close may release the lines legally.
   close_pfl_a: assert property ((clean_close
      and (!$past(CTL_I.commit) && !$past(CTL_I.dev_reset)))
      ##1 !CTL_I.dev_reset |-> ##1 TERM_OE_O.pfl == $past(TERM_OE_O.pfl, 2))
      else $error("Function line drive changed on close.");
   dev_rst_a: assert property (CTL_I.dev_reset |-> ##2 TERM_OE_O == '0)
      else $error("Lines still driven after device reset.");
   rate_bad_a: assert property (REF_WR_I
      && REF_RATE_I != trgx_pkg::REF_RATE_HZ |=> REFUSED_O)
      else $error("Bad reference rate accepted.");
   slot_bad_a: assert property (BPC_WR_I
      && SLOT_I != trgx_pkg::REQUIRED_SLOT |=> REFUSED_O)
      else $error("Backplane clock set outside its slot.");
   term_bad_a: assert property (SEL_WR_I
      && SEL_TERM_I > 4'hB |=> REFUSED_O)
      else $error("Unknown terminal code accepted.");
endmodule : trgx_top_sva
bind trgx_top trgx_top_sva trgx_top_sva_inst (.CLK_I, .RST_N_I, .SEL_WR_I,
   .SEL_TERM_I, .REF_WR_I, .REF_RATE_I, .BPC_WR_I, .SLOT_I, .CTL_I,
   .TERM_OE_O, .CLK_CFG_O, .REFUSED_O);

// *** verif/trgx_top_bench.sv ***
// Purpose: Self-checking bench for the export router.
// Assumes: Inputs change at the falling clock edge.
// Notes: Drivers queue expected port words for one monitor.
`timescale 1ns/10ps
module trgx_top_bench;
   logic clk = 1'b0, rst_n = 1'b0, sel_wr = 1'b0, ref_wr = 1'b0;
   logic bpc_wr = 1'b0, refused, cls = 1'b0;
   logic [7:0] ev = 8'h00, rnd = 8'h3B;
   logic [2:0] sel_sig = 3'h0;
   logic [3:0] sel_term = 4'h0, slot = 4'h2, scfg = 4'h0, mcfg = 4'h0;
   logic [1:0] ref_src = 2'h0, bpc_src = 2'h0;
   logic [31:0] ref_rate = trgx_pkg::REF_RATE_HZ;
   logic [3:0] shd [8] = '{default: 4'h0};
   logic [3:0] act [8] = '{default: 4'h0};
   trgx_pkg::trgx_ctl_t ctl = 3'h0;
   trgx_pkg::trgx_term_t term, oe, lvl;
   trgx_pkg::trgx_clk_cfg_t cfg;
   int miscompares = 0, checked = 0, cycles = 0;
   logic [26:0] exp_q [$];
   event seen;
   wire [26:0] obs = {refused, cfg, oe, lvl};
   trgx_top trgx_top_inst (.CLK_I(clk), .RST_N_I(rst_n), .EVENT_I(ev),
      .SEL_WR_I(sel_wr), .SEL_SIG_I(sel_sig), .SEL_TERM_I(sel_term),
      .REF_WR_I(ref_wr), .REF_SRC_I(ref_src), .REF_RATE_I(ref_rate),
      .BPC_WR_I(bpc_wr), .BPC_SRC_I(bpc_src), .SLOT_I(slot), .CTL_I(ctl),
      .TERM_O(term), .TERM_OE_O(oe), .CLK_CFG_O(cfg), .REFUSED_O(refused));
   trgx_peer trgx_peer_inst (.term_i(term), .oe_i(oe), .lvl_o(lvl));
   // Clock source.
   always #25 clk = ~clk;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // Expected port word from the routing and clock model.
   function automatic logic [26:0] model(input logic r);
      logic [10:0] m;
      logic [10:0] v;
      int b;
      m = 11'h000;
      v = 11'h000;
      foreach (act[i]) begin
         b = act[i] < 3 ? 8 + act[i] : (act[i] == 11 ? 0 : act[i] - 2);
         if (act[i] != 4'h0) begin
            m[b] = 1'b1;
            v[b] = v[b] | ev[i];
         end
      end
      if (cls) m[8:0] = 9'h000;
      return {r, mcfg, m, (v & m) | ~m};
   endfunction : model
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic chk(input logic r);
      exp_q.push_back(model(r));
      -> seen;
   endtask : chk
   // One strobe: 0 route, 1 ref, 2 backplane clock, 3-5 control.
   task automatic put(input int k, input logic bad);
      if (k == 0) sel_wr = 1'b1;
      else if (k == 1) ref_wr = 1'b1;
      else if (k == 2) bpc_wr = 1'b1;
      else ctl = trgx_pkg::trgx_ctl_t'(3'h4 >> (k - 3));
      cyc(1);
      if (k < 3) chk(bad);
      if (!bad && k == 0) shd[sel_sig] = sel_term;
      if (!bad && k == 1) scfg[3:2] = ref_src;
      if (!bad && k == 2) scfg[1:0] = bpc_src;
      if (k == 3) begin
         act = shd;
         mcfg = scfg;
         cls = 1'b0;
      end
      if (k == 4) cls = 1'b1;
      if (k == 5) shd = '{default: 4'h0};
      if (k == 5) act = shd;
      {sel_wr, ref_wr, bpc_wr, ctl} = 6'h00;
      cyc(1);
   endtask : put
   // Compares the oldest queued word with the ports.
   always @(seen) begin
      logic [26:0] e;
      e = exp_q.pop_front();
      checked++;
      if (obs !== e) begin
         miscompares++;
         $display("mismatch ports expected %h seen %h", e, obs);
      end
   end
   task automatic finish_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      chk(1'b0);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         ev = rnd;
         sel_sig = 3'(i);
         sel_term = 4'(rnd % 12);
         put(0, 1'b0);
      end
      put(3, 1'b0);
      cyc(2);
      chk(1'b0);
      sel_sig = 3'h0;
      sel_term = act[0] == 4'hB ? 4'h1 : act[0] + 4'h1;
      put(0, 1'b0);
      sel_sig = 3'h1;
      sel_term = 4'h0;
      put(0, 1'b0);
      put(3, 1'b0);
      cyc(2);
      chk(1'b0);
      $display("routing test done");
      sel_term = 4'hC;
      put(0, 1'b1);
      ref_rate = ref_rate + 32'h1;
      put(1, 1'b1);
      ref_rate = trgx_pkg::REF_RATE_HZ;
      ref_src = 2'h3;
      put(1, 1'b1);
      slot = 4'h5;
      bpc_src = 2'h1;
      put(2, 1'b1);
      slot = 4'h2;
      $display("refusal test done");
      put(4, 1'b0);
      cyc(2);
      chk(1'b0);
      put(3, 1'b0);
      put(4, 1'b0);
      cyc(2);
      chk(1'b0);
      put(5, 1'b0);
      cyc(2);
      chk(1'b0);
      $display("close test done");
      for (int i = 0; i < 9; i++) begin
         ref_src = 2'(i % 3);
         bpc_src = 2'(i / 3);
         put(1, 1'b0);
         put(2, 1'b0);
         put(3, 1'b0);
         chk(1'b0);
      end
      $display("clock test done");
      finish_test();
   end
endmodule : trgx_top_bench
